// File: design/picd_pkg.sv
package picd_pkg;

    // Register addresses carried in the command byte
    localparam logic [3:0] ADDR_WIPER0 = 4'h0;
    localparam logic [3:0] ADDR_WIPER1 = 4'h1;
    localparam logic [3:0] ADDR_RSVD_A = 4'h2;
    localparam logic [3:0] ADDR_RSVD_B = 4'h3;
    localparam logic [3:0] ADDR_TERM_CONN = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h5;
    localparam logic [3:0] PTR_RESET = 4'h0;

    // Operation codes of cmd_op_field
    localparam logic [1:0] OP_WRITE = 2'h0;
    localparam logic [1:0] OP_INC = 2'h1;
    localparam logic [1:0] OP_DEC = 2'h2;
    localparam logic [1:0] OP_READ = 2'h3;

    // Command byte field positions
    localparam int CMD_ADDR_MSB = 7;
    localparam int CMD_ADDR_LSB = 4;
    localparam int CMD_OP_MSB = 3;
    localparam int CMD_OP_LSB = 2;
    localparam int CMD_BIT9_POS = 1;
    localparam int CMD_BIT8_POS = 0;

    // Stored data width and value limits
    localparam int DATA_W = 9;
    localparam logic [8:0] WIPER_MAX_8 = 9'h100;
    localparam logic [8:0] WIPER_MAX_7 = 9'h080;
    localparam logic [8:0] WIPER_MID_8 = 9'h080;
    localparam logic [8:0] WIPER_MID_7 = 9'h040;
    localparam logic [8:0] TERM_CONN_RESET = 9'h1ff;
    localparam logic [8:0] STATUS_VALUE = 9'h000;

    // Serial logic states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CMD = 3'b001,
        ST_DATA = 3'b010,
        ST_READ = 3'b011,
        ST_ERR = 3'b100
    } picd_state_type;

endpackage

// File: design/picd_step.sv
`timescale 1ns/1ps
module picd_step
    import picd_pkg::*;
#(
    parameter logic [8:0] MAX_VALUE = 9'h100
)
(
    // Current value and requested step
    input wire logic [8:0] value_in,
    input wire logic inc_in,
    input wire logic dec_in,
    // Stepped value
    output logic [8:0] value_out
);

    // Saturate at full scale going up and at zero going down
    always_comb
    begin
        value_out = value_in;
        if (inc_in && (value_in < MAX_VALUE))
        begin
            value_out = value_in + 9'h001; // see [RULE22]
        end
        else if (dec_in && (value_in != 9'h000))
        begin
            value_out = value_in - 9'h001; // see [RULE23]
        end
    end

endmodule

// File: design/picd_top.sv
// What this block does
// [RULE1] Command byte splits into address, operation and two data bits; only data_bit8 matters.
// [RULE2] cmd_addr_field picks the location; cmd_op_field picks read, write, increment, decrement.
// [RULE3] Increment and decrement are refused at terminal control and every higher address.
// [RULE4] A supported address and operation pair is acknowledged.
// [RULE5] An unsupported pair gets a not-acknowledge in the command byte slot.
// [RULE6] After an error every command is ignored until a new Start.
// [RULE7] Master issues a Start after a rejected command before sending more.
// [RULE8] data_bit9 and data_bit8 are the top positions of the wiper value.
// [RULE9] A write joins data_bit8 above the data byte into nine bits.
// [RULE10] Write values at or above full scale are accepted; data_bit9 is unused.
// [RULE11] Only reads and writes carry data bytes; increment and decrement are command only.
// [RULE12] Each location stores nine bits; the top bit of the ten is ignored.
// [RULE13] A read returns two bytes holding the ten-bit data field.
// [RULE14] Stop or repeated Start where data was expected abandons the sequence.
// [RULE15] Write is control byte, ack, command, ack, data, ack; device drives each ack.
// [RULE16] A location updates only at the final acknowledge clock of a complete write.
// [RULE17] Master drives high_voltage_cmd_pin normal or elevated; both offer the same operations.
// [RULE18] Single command 29 clocks; continuous 18n+11, increment or decrement 9n+11.
// [RULE19] Wiper 0 at 00h, wiper 1 at 01h, terminal control at 04h; mixed writes allowed.
// [RULE20] A Stop or repeated Start before the data acknowledge discards the write.
// [RULE21] Address pointer resets to 00h and survives Stop and repeated Start.
// [RULE22] Increment adds one, saturating at 100h or 80h by resolution.
// [RULE23] Decrement subtracts one and holds at zero.
// [RULE24] After an abort the logic stays idle until Start and control byte select it.
`timescale 1ns/1ps
module picd_top
    import picd_pkg::*;
#(
    parameter bit EIGHT_BIT = 1'b1
)
(
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    // Bus conditions from the byte layer
    input wire logic BUS_START_IN,
    input wire logic BUS_STOP_IN,
    input wire logic CTRL_SEL_IN,
    input wire logic CTRL_RW_IN,
    input wire logic HIGH_VOLTAGE_CMD_PIN_IN,
    // Received bytes and acknowledge slot clock
    input wire logic RX_VALID_IN,
    input wire logic [7:0] RX_BYTE_IN,
    input wire logic ACK_CLK_IN,
    // Transmit requests and master acknowledge
    input wire logic TX_REQ_IN,
    input wire logic MST_ACK_VALID_IN,
    input wire logic MST_ACK_IN,
    // Acknowledge answer
    output logic ACK_VALID_OUT,
    output logic ACK_OUT,
    // Read data
    output logic TX_VALID_OUT,
    output logic [7:0] TX_BYTE_OUT,
    // Volatile registers and status
    output logic [8:0] WIPER0_OUT,
    output logic [8:0] WIPER1_OUT,
    output logic [8:0] TERM_CONN_OUT,
    output logic [3:0] ADDR_PTR_OUT,
    output logic ERROR_OUT,
    output logic CMD_HIGH_VOLTAGE_OUT
);

    localparam logic [8:0] WIPER_MAX = EIGHT_BIT ? WIPER_MAX_8 : WIPER_MAX_7;
    localparam logic [8:0] WIPER_MID = EIGHT_BIT ? WIPER_MID_8 : WIPER_MID_7;

    picd_state_type state_q, state_d;
    logic err_q, err_d, pend_q, pend_d, bit8_q, bit8_d, rd_idx_q, rd_idx_d, hv_q, hv_d;
    logic ack_q, ack_d, ack_v_q, ack_v_d, tx_v_q, tx_v_d, cmd_ok, exec;
    logic [3:0] ptr_q, ptr_d, pend_addr_q, pend_addr_d, cmd_addr;
    logic [1:0] pend_op_q, pend_op_d, cmd_op;
    logic [7:0] tx_q, tx_d;
    logic [8:0] pend_data_q, pend_data_d, w0_step, w1_step, rd_word;
    logic [8:0] w0_q, w0_d, w1_q, w1_d, term_q, term_d;

    // Field split of the command byte; data_bit9 is dropped here
    assign cmd_addr = RX_BYTE_IN[CMD_ADDR_MSB:CMD_ADDR_LSB]; // see [RULE1] see [RULE2]
    assign cmd_op = RX_BYTE_IN[CMD_OP_MSB:CMD_OP_LSB]; // see [RULE2]

    // Supported address and operation pairs
    always_comb
    begin
        cmd_ok = 1'b0;
        case (cmd_op)
            OP_WRITE: cmd_ok = (cmd_addr == ADDR_WIPER0) || (cmd_addr == ADDR_WIPER1)
                || (cmd_addr == ADDR_TERM_CONN); // see [RULE19]
            OP_READ: cmd_ok = (cmd_addr == ADDR_WIPER0) || (cmd_addr == ADDR_WIPER1)
                || (cmd_addr == ADDR_TERM_CONN) || (cmd_addr == ADDR_STATUS);
            OP_INC, OP_DEC: cmd_ok = (cmd_addr == ADDR_WIPER0) || (cmd_addr == ADDR_WIPER1); // see [RULE3]
            default: cmd_ok = 1'b0;
        endcase
    end

    // A pending update lands only on its acknowledge clock, never alongside an abort
    assign exec = ACK_CLK_IN && pend_q && !BUS_START_IN && !BUS_STOP_IN; // see [RULE16]

    // Read data multiplexer; reserved slots read as zero
    always_comb
    begin
        case (ptr_q)
            ADDR_WIPER0: rd_word = w0_q;
            ADDR_WIPER1: rd_word = w1_q;
            ADDR_TERM_CONN: rd_word = term_q;
            ADDR_STATUS: rd_word = STATUS_VALUE;
            default: rd_word = 9'h000;
        endcase
    end

    // Protocol sequencing: next state of the serial logic
    always_comb
    begin
        state_d = state_q;
        err_d = err_q;
        ptr_d = ptr_q;
        pend_d = pend_q && !exec;
        pend_op_d = pend_op_q;
        pend_addr_d = pend_addr_q;
        pend_data_d = pend_data_q;
        bit8_d = bit8_q;
        rd_idx_d = rd_idx_q;
        hv_d = hv_q;
        ack_d = ack_q;
        ack_v_d = 1'b0;
        tx_v_d = 1'b0;
        tx_d = tx_q;
        if (BUS_START_IN)
        begin
            // Start clears an error and drops any unfinished write
            state_d = ST_IDLE; // see [RULE6] see [RULE24]
            err_d = 1'b0;
            pend_d = 1'b0; // see [RULE14] see [RULE20]
        end
        else if (BUS_STOP_IN)
        begin
            // A Stop alone does not clear an error; only a Start does
            state_d = err_q ? ST_ERR : ST_IDLE; // see [RULE6] see [RULE14] see [RULE24]
            pend_d = 1'b0; // see [RULE20]
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (CTRL_SEL_IN)
                    begin
                        state_d = CTRL_RW_IN ? ST_READ : ST_CMD;
                        rd_idx_d = 1'b0;
                    end
                end
                ST_CMD:
                begin
                    if (RX_VALID_IN)
                    begin
                        ack_v_d = 1'b1; // see [RULE15]
                        hv_d = HIGH_VOLTAGE_CMD_PIN_IN; // Both levels decode alike
                        if (cmd_ok)
                        begin
                            ack_d = 1'b1; // see [RULE4]
                            ptr_d = cmd_addr; // see [RULE21]
                            if (cmd_op == OP_WRITE)
                            begin
                                state_d = ST_DATA;
                                bit8_d = RX_BYTE_IN[CMD_BIT8_POS]; // see [RULE8]
                            end
                            else if (cmd_op != OP_READ)
                            begin
                                // No data byte follows; the next byte is a command again
                                pend_d = 1'b1; // see [RULE11] see [RULE18]
                                pend_op_d = cmd_op;
                                pend_addr_d = cmd_addr;
                            end
                        end
                        else
                        begin
                            ack_d = 1'b0; // see [RULE5]
                            err_d = 1'b1;
                            state_d = ST_ERR;
                        end
                    end
                end
                ST_DATA:
                begin
                    if (RX_VALID_IN)
                    begin
                        ack_v_d = 1'b1; // see [RULE15]
                        ack_d = 1'b1;
                        pend_d = 1'b1;
                        pend_op_d = OP_WRITE;
                        pend_addr_d = ptr_q;
                        pend_data_d = {bit8_q, RX_BYTE_IN}; // see [RULE9] see [RULE10] see [RULE12]
                        state_d = ST_CMD; // Continuous writes may change address, see [RULE18]
                    end
                end
                ST_READ:
                begin
                    if (TX_REQ_IN)
                    begin
                        // High byte first: data_bit9 reads zero, then data_bit8
                        tx_v_d = 1'b1;
                        tx_d = rd_idx_q ? rd_word[7:0] : {7'h00, rd_word[8]}; // see [RULE13]
                        rd_idx_d = !rd_idx_q;
                    end
                    else if (MST_ACK_VALID_IN && !MST_ACK_IN)
                    begin
                        state_d = ST_IDLE; // Master nack releases the bus
                    end
                end
                ST_ERR: state_d = ST_ERR; // see [RULE6]
                default: state_d = ST_IDLE;
            endcase
        end
    end

    // Saturating steppers for the two wipers
    picd_step #(.MAX_VALUE(WIPER_MAX)) u_step0 (
        .value_in(w0_q),
        .inc_in(pend_op_q == OP_INC),
        .dec_in(pend_op_q == OP_DEC),
        .value_out(w0_step)
    );
    picd_step #(.MAX_VALUE(WIPER_MAX)) u_step1 (
        .value_in(w1_q),
        .inc_in(pend_op_q == OP_INC),
        .dec_in(pend_op_q == OP_DEC),
        .value_out(w1_step)
    );

    // Register updates at the acknowledge clock
    always_comb
    begin
        w0_d = w0_q;
        w1_d = w1_q;
        term_d = term_q;
        if (exec)
        begin
            case (pend_addr_q)
                ADDR_WIPER0: w0_d = (pend_op_q == OP_WRITE) ? pend_data_q : w0_step; // see [RULE16]
                ADDR_WIPER1: w1_d = (pend_op_q == OP_WRITE) ? pend_data_q : w1_step; // see [RULE19]
                ADDR_TERM_CONN: term_d = pend_data_q;
                default: term_d = term_q;
            endcase
        end
    end

    // State registers
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            state_q <= ST_IDLE;
            err_q <= 1'b0;
            ptr_q <= PTR_RESET; // see [RULE21]
            pend_q <= 1'b0;
            pend_op_q <= OP_WRITE;
            pend_addr_q <= ADDR_WIPER0;
            pend_data_q <= 9'h000;
            bit8_q <= 1'b0;
            rd_idx_q <= 1'b0;
            hv_q <= 1'b0;
            ack_q <= 1'b0;
            ack_v_q <= 1'b0;
            tx_v_q <= 1'b0;
            tx_q <= 8'h00;
            w0_q <= WIPER_MID;
            w1_q <= WIPER_MID;
            term_q <= TERM_CONN_RESET;
        end
        else
        begin
            state_q <= state_d;
            err_q <= err_d;
            ptr_q <= ptr_d;
            pend_q <= pend_d;
            pend_op_q <= pend_op_d;
            pend_addr_q <= pend_addr_d;
            pend_data_q <= pend_data_d;
            bit8_q <= bit8_d;
            rd_idx_q <= rd_idx_d;
            hv_q <= hv_d;
            ack_q <= ack_d;
            ack_v_q <= ack_v_d;
            tx_v_q <= tx_v_d;
            tx_q <= tx_d;
            w0_q <= w0_d;
            w1_q <= w1_d;
            term_q <= term_d;
        end
    end

    // Outputs straight from flip-flops
    assign ACK_VALID_OUT = ack_v_q;
    assign ACK_OUT = ack_q;
    assign TX_VALID_OUT = tx_v_q;
    assign TX_BYTE_OUT = tx_q;
    assign WIPER0_OUT = w0_q;
    assign WIPER1_OUT = w1_q;
    assign TERM_CONN_OUT = term_q;
    assign ADDR_PTR_OUT = ptr_q;
    assign ERROR_OUT = err_q;
    assign CMD_HIGH_VOLTAGE_OUT = hv_q;

    // Checks on the decoder, register updates, bus conditions and read data
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN);

    a_ack_good_pair: assert property (state_q == ST_CMD && RX_VALID_IN && !BUS_START_IN && !BUS_STOP_IN // see [RULE4]
        && cmd_ok |=> ACK_VALID_OUT && ACK_OUT) else $error("Valid command not acknowledged");
    a_nack_bad_pair: assert property (state_q == ST_CMD && RX_VALID_IN && !BUS_START_IN && !BUS_STOP_IN // see [RULE5]
        && !cmd_ok |=> ACK_VALID_OUT && !ACK_OUT && ERROR_OUT) else $error("Invalid command not refused");
    a_step_high_addr: assert property (state_q == ST_CMD && RX_VALID_IN // see [RULE3]
        && !BUS_START_IN && !BUS_STOP_IN && cmd_addr >= ADDR_TERM_CONN && (cmd_op == OP_INC || cmd_op == OP_DEC)
        |=> !ACK_OUT) else $error("Step accepted at high address");
    a_error_ignores: assert property (ERROR_OUT && !BUS_START_IN // see [RULE6]
        |=> ERROR_OUT && !ACK_VALID_OUT && !TX_VALID_OUT) else $error("Command served in error");
    a_write_lands: assert property (exec && pend_op_q == OP_WRITE && pend_addr_q == ADDR_WIPER0 // see [RULE16]
        |=> WIPER0_OUT == $past(pend_data_q)) else $error("Wiper 0 write lost");
    a_abort_drops: assert property (pend_q && (BUS_STOP_IN || BUS_START_IN) // see [RULE20]
        |=> !pend_q && $stable(WIPER0_OUT) && $stable(WIPER1_OUT) && $stable(TERM_CONN_OUT))
        else $error("Write survived abort");
    a_ptr_kept: assert property (BUS_STOP_IN || BUS_START_IN // see [RULE21]
        |=> $stable(ADDR_PTR_OUT)) else $error("Pointer lost on bus condition");
    a_inc_saturates: assert property (exec && pend_op_q == OP_INC // see [RULE22]
        && (pend_addr_q == ADDR_WIPER0 ? w0_q : w1_q) >= WIPER_MAX
        |=> $stable(WIPER0_OUT) && $stable(WIPER1_OUT)) else $error("Increment past full scale");
    a_dec_floor: assert property (exec && pend_op_q == OP_DEC // see [RULE23]
        && (pend_addr_q == ADDR_WIPER0 ? w0_q : w1_q) == 9'h000
        |=> $stable(WIPER0_OUT) && $stable(WIPER1_OUT)) else $error("Decrement below zero");
    a_read_high_byte: assert property (state_q == ST_READ && TX_REQ_IN && !rd_idx_q // see [RULE13]
        && !BUS_START_IN && !BUS_STOP_IN |=> TX_VALID_OUT && TX_BYTE_OUT[7:1] == 7'h00 ##0 rd_idx_q)
        else $error("Read high byte malformed");

    c_write: cover property (exec && pend_op_q == OP_WRITE);
    c_increment: cover property (exec && pend_op_q == OP_INC);
    c_read_pair: cover property (TX_VALID_OUT ##[1:20] TX_VALID_OUT);
    c_error: cover property (ACK_VALID_OUT && !ACK_OUT);

endmodule

// File: tb/picd_master_model.sv
`timescale 1ns/1ps
module picd_master_model
(
    // Clock
    input wire logic clk_in,
    // Bus conditions and received bytes
    output logic start_out,
    output logic stop_out,
    output logic sel_out,
    output logic rw_out,
    output logic rx_valid_out,
    output logic [7:0] rx_byte_out,
    output logic ack_clk_out,
    // Read side requests
    output logic tx_req_out,
    output logic mst_ack_valid_out,
    output logic mst_ack_out,
    // Device answers
    input wire logic ack_valid_in,
    input wire logic ack_in,
    input wire logic tx_valid_in,
    input wire logic [7:0] tx_byte_in
);
    // Idle levels; the byte bus carries a pattern so a stale value is never mistaken for data
    initial
    begin
        start_out = 1'b0;
        stop_out = 1'b0;
        sel_out = 1'b0;
        rw_out = 1'b0;
        rx_valid_out = 1'b0;
        rx_byte_out = 8'h5a;
        ack_clk_out = 1'b0;
        tx_req_out = 1'b0;
        mst_ack_valid_out = 1'b0;
        mst_ack_out = 1'b0;
    end

    // Start or Stop pulse; a Start after a refused command returns the device to idle
    task automatic cond(input bit s, input bit p);
        @(posedge clk_in);
        #1 start_out = s;
        stop_out = p;
        @(posedge clk_in);
        #1 start_out = 1'b0;
        stop_out = 1'b0;
    endtask

    // Control byte that matched this device
    task automatic select(input bit rw);
        @(posedge clk_in);
        #1 sel_out = 1'b1;
        rw_out = rw;
        @(posedge clk_in);
        #1 sel_out = 1'b0;
        rw_out = ~rw;
    endtask

    // One received byte; the answer stands one cycle, so it is taken at once
    task automatic send_byte(input logic [7:0] b, output logic got, output logic ack);
        @(posedge clk_in);
        #1 rx_valid_out = 1'b1;
        rx_byte_out = b;
        @(posedge clk_in);
        #1 rx_valid_out = 1'b0;
        rx_byte_out = ~b;
        got = ack_valid_in;
        ack = ack_in;
    endtask

    // Acknowledge slot clock, kept two cycles clear of the byte before it
    task automatic ack_clock();
        repeat (2) @(posedge clk_in);
        #1 ack_clk_out = 1'b1;
        @(posedge clk_in);
        #1 ack_clk_out = 1'b0;
        repeat (2) @(posedge clk_in);
        #1;
    endtask

    // One transmitted byte followed by the master's own acknowledge slot
    task automatic read_byte(input logic m, output logic got, output logic [7:0] b);
        @(posedge clk_in);
        #1 tx_req_out = 1'b1;
        @(posedge clk_in);
        #1 tx_req_out = 1'b0;
        got = tx_valid_in;
        b = tx_byte_in;
        repeat (2) @(posedge clk_in);
        #1 mst_ack_valid_out = 1'b1;
        mst_ack_out = m;
        @(posedge clk_in);
        #1 mst_ack_valid_out = 1'b0;
        mst_ack_out = ~m;
    endtask
endmodule

// File: tb/picd_top_bench.sv
`timescale 1ns/1ps
module picd_top_bench
    import picd_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hv = 1'b0;
    logic start, stop, sel, rw, rx_valid, ack_clk, tx_req, mack_v, mack;
    logic [7:0] rx_byte;
    logic ack_valid, ack, tx_valid, err, hvo;
    logic [7:0] tx_byte;
    logic [8:0] w0, w1, term;
    logic [3:0] ptr;
    int n_fail = 0;
    int compares = 0;

    // 200 MHz clock
    always #2.5 clk = ~clk;

    // Device under test and the master side driving its byte layer
    picd_top #(.EIGHT_BIT(1'b1)) i_dut (.CLK_IN(clk), .SYS_RST_IN(rst), .BUS_START_IN(start),
        .BUS_STOP_IN(stop), .CTRL_SEL_IN(sel), .CTRL_RW_IN(rw), .HIGH_VOLTAGE_CMD_PIN_IN(hv),
        .RX_VALID_IN(rx_valid), .RX_BYTE_IN(rx_byte), .ACK_CLK_IN(ack_clk), .TX_REQ_IN(tx_req),
        .MST_ACK_VALID_IN(mack_v), .MST_ACK_IN(mack), .ACK_VALID_OUT(ack_valid), .ACK_OUT(ack),
        .TX_VALID_OUT(tx_valid), .TX_BYTE_OUT(tx_byte), .WIPER0_OUT(w0), .WIPER1_OUT(w1),
        .TERM_CONN_OUT(term), .ADDR_PTR_OUT(ptr), .ERROR_OUT(err), .CMD_HIGH_VOLTAGE_OUT(hvo));
    picd_master_model i_mst (.clk_in(clk), .start_out(start), .stop_out(stop), .sel_out(sel),
        .rw_out(rw), .rx_valid_out(rx_valid), .rx_byte_out(rx_byte), .ack_clk_out(ack_clk),
        .tx_req_out(tx_req), .mst_ack_valid_out(mack_v), .mst_ack_out(mack),
        .ack_valid_in(ack_valid), .ack_in(ack), .tx_valid_in(tx_valid), .tx_byte_in(tx_byte));

    task automatic summarize();
        $display("checks: %0d compares, %0d mismatches", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk_val(input logic [8:0] got, input logic [8:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_val({8'h00, got}, {8'h00, exp});
    endtask

    function automatic logic [7:0] cmdb(input logic [3:0] a, input logic [1:0] op, input logic b9, input logic b8);
        return {a, op, b9, b8};
    endfunction

    // Send one byte and judge whether and how it was answered
    task automatic put(input logic [7:0] b, input logic ev, input logic ea, input bit clk_ack);
        logic g;
        logic a;
        i_mst.send_byte(b, g, a);
        chk_bit(g, ev);
        if (ev)
            chk_bit(a, ea);
        if (clk_ack)
            i_mst.ack_clock();
    endtask

    task automatic open(input bit rw_bit);
        i_mst.cond(1'b1, 1'b0);
        i_mst.select(rw_bit);
    endtask

    task automatic rd(input logic m, input logic [7:0] exp);
        logic g;
        logic [7:0] b;
        i_mst.read_byte(m, g, b);
        chk_bit(g, 1'b1);
        chk_val({1'b0, b}, {1'b0, exp});
    endtask

    task automatic t_reset();
        chk_val(w0, WIPER_MID_8);
        chk_val(w1, WIPER_MID_8);
        chk_val(term, TERM_CONN_RESET);
        chk_val({5'h00, ptr}, {5'h00, PTR_RESET});
        chk_bit(err, 1'b0);
        chk_bit(ack, 1'b0);
        chk_val({1'b0, tx_byte}, 9'h000);
        $display("test reset done");
    endtask

    // Single and continuous writes, a late abort, and a byte sent while idle
    task automatic t_write();
        open(1'b0);
        put(cmdb(ADDR_WIPER0, OP_WRITE, 1'b1, 1'b1), 1'b1, 1'b1, 1'b1);
        put(8'h23, 1'b1, 1'b1, 1'b0);
        chk_val(w0, WIPER_MID_8);
        i_mst.ack_clock();
        chk_val(w0, 9'h123);
        put(cmdb(ADDR_WIPER1, OP_WRITE, 1'b0, 1'b1), 1'b1, 1'b1, 1'b1);
        put(8'hff, 1'b1, 1'b1, 1'b1);
        chk_val(w1, 9'h1ff);
        hv = 1'b1;
        put(cmdb(ADDR_TERM_CONN, OP_WRITE, 1'b0, 1'b0), 1'b1, 1'b1, 1'b1);
        chk_bit(hvo, 1'b1);
        hv = 1'b0;
        put(8'h5a, 1'b1, 1'b1, 1'b1);
        chk_val(term, 9'h05a);
        put(cmdb(ADDR_WIPER0, OP_WRITE, 1'b0, 1'b0), 1'b1, 1'b1, 1'b1);
        chk_bit(hvo, 1'b0);
        put(8'h77, 1'b1, 1'b1, 1'b0);
        i_mst.cond(1'b0, 1'b1);
        i_mst.ack_clock();
        chk_val(w0, 9'h123);
        chk_val({5'h00, ptr}, {5'h00, ADDR_WIPER0});
        put(cmdb(ADDR_WIPER0, OP_WRITE, 1'b0, 1'b0), 1'b0, 1'b0, 1'b1);
        $display("test write done");
    endtask

    // Increment and decrement at both ends of the range, commands with no data byte
    task automatic t_step();
        open(1'b0);
        put(cmdb(ADDR_WIPER0, OP_WRITE, 1'b0, 1'b0), 1'b1, 1'b1, 1'b1);
        put(8'hff, 1'b1, 1'b1, 1'b1);
        put(cmdb(ADDR_WIPER0, OP_INC, 1'b0, 1'b0), 1'b1, 1'b1, 1'b1);
        chk_val(w0, WIPER_MAX_8);
        put(cmdb(ADDR_WIPER0, OP_INC, 1'b0, 1'b0), 1'b1, 1'b1, 1'b1);
        chk_val(w0, WIPER_MAX_8);
        put(cmdb(ADDR_WIPER0, OP_DEC, 1'b0, 1'b0), 1'b1, 1'b1, 1'b1);
        chk_val(w0, 9'h0ff);
        put(cmdb(ADDR_WIPER1, OP_WRITE, 1'b0, 1'b0), 1'b1, 1'b1, 1'b1);
        put(8'h00, 1'b1, 1'b1, 1'b1);
        put(cmdb(ADDR_WIPER1, OP_DEC, 1'b0, 1'b0), 1'b1, 1'b1, 1'b1);
        chk_val(w1, 9'h000);
        put(cmdb(ADDR_WIPER1, OP_INC, 1'b0, 1'b0), 1'b1, 1'b1, 1'b1);
        chk_val(w1, 9'h001);
        i_mst.cond(1'b0, 1'b1);
        $display("test step done");
    endtask

    // Every address and operation pair; refused ones must lock out until a Start
    task automatic t_pairs();
        logic [3:0] a;
        logic [1:0] op;
        logic ok;
        for (int i = 0; i < 64; i++)
        begin
            a = i[5:2];
            op = i[1:0];
            ok = (op == OP_WRITE && (a == 4'h0 || a == 4'h1 || a == 4'h4))
                || (op == OP_READ && (a == 4'h0 || a == 4'h1 || a == 4'h4 || a == 4'h5))
                || ((op == OP_INC || op == OP_DEC) && a <= 4'h1);
            open(1'b0);
            put(cmdb(a, op, 1'b0, 1'b0), 1'b1, ok, 1'b0);
            chk_bit(err, ~ok);
            if (!ok)
            begin
                put(cmdb(ADDR_WIPER0, OP_WRITE, 1'b0, 1'b0), 1'b0, 1'b0, 1'b1);
                put(8'h11, 1'b0, 1'b0, 1'b1);
                chk_val(w0, 9'h0ff);
            end
            i_mst.cond(1'b1, 1'b0);
            chk_bit(err, 1'b0);
        end
        $display("test pairs done");
    endtask

    // Read two bytes, then continue into a second pair before the closing not-acknowledge
    task automatic rd_reg(input logic [3:0] a, input logic [8:0] v);
        open(1'b0);
        put(cmdb(a, OP_READ, 1'b0, 1'b0), 1'b1, 1'b1, 1'b1);
        chk_val({5'h00, ptr}, {5'h00, a});
        i_mst.cond(1'b1, 1'b0);
        i_mst.select(1'b1);
        rd(1'b1, {7'h00, v[8]});
        rd(1'b1, v[7:0]);
        rd(1'b1, {7'h00, v[8]});
        rd(1'b0, v[7:0]);
        i_mst.cond(1'b0, 1'b1);
    endtask

    task automatic t_read();
        rd_reg(ADDR_WIPER0, 9'h0ff);
        rd_reg(ADDR_WIPER1, 9'h001);
        rd_reg(ADDR_TERM_CONN, 9'h05a);
        rd_reg(ADDR_STATUS, STATUS_VALUE);
        $display("test read done");
    endtask

    // Hang guard
    initial
    begin
        repeat (60000) @(posedge clk);
        n_fail++;
        summarize();
    end

    // Main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        t_reset();
        t_write();
        t_step();
        t_pairs();
        t_read();
        summarize();
    end
endmodule
